// file: hdl/bsc_pkg.sv
// constants and types shared by the coupler self-test block
package bsc_pkg;
    // register byte addresses on the avalon slave
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    // control and status field positions
    localparam int CTRL_TS_BIT  = 0;
    localparam int STAT_CODE_LO = 0;
    localparam int STAT_POL_BIT = 2;
    localparam int STAT_FLT_BIT = 3;
    localparam int STAT_ERR_LO  = 4;
    localparam int STAT_BSY_BIT = 6;
    // status codes
    localparam logic [1:0] ST_FAULT = 2'h0;
    localparam logic [1:0] ST_ONE   = 2'h1;
    localparam logic [1:0] ST_TWO   = 2'h2;
    localparam logic [1:0] ST_NONE  = 2'h3;
    // coupler error limit and deleted transitions
    localparam logic [1:0] ERR_LIMIT  = 2'h3;
    localparam logic [1:0] SUPP_TRANS = 2'h2;
    // wraparound settle time after the inverted wordstring
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int WRAP_DELAY_PS  = 750000;
    localparam int WRAP_DELAY_CYC = (WRAP_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [6:0] WRAP_DELAY_CNT = 7'(WRAP_DELAY_CYC);
    // reset values
    localparam logic [1:0] RST_STATUS = ST_NONE;
    // link-side observations from the stub transceiver
    typedef struct packed {
        logic tx_idle;       // transmit_idle_flag, high between wordstrings
        logic bus_quiet;     // bus quiet detected
        logic tx_doublet;    // pulse: valid doublet driven on transmit stub
        logic rx_doublet;    // pulse: valid doublet seen on wraparound
        logic wrap_inverted; // wraparound shows inverted doublet polarity
        logic quality_err;   // pulse: amplitude or symmetry problem
        logic unit_fault;    // pulse: error located in the unit itself
        logic tx_defect;     // level: own transmitter found defective
    } bsc_link_t;
    // test sequence states
    typedef enum logic [2:0] {
        T_IDLE,
        T_ARMED,
        T_PRIMED,
        T_RUN,
        T_DELAY
    } bsc_test_t;
endpackage : bsc_pkg

// file: hdl/bsc_selftest.sv
// coupler channel select, fault handling and built-in channel test
// Operation
// [R1] check wraparound quality on every transmission
// [R2] exactly one channel, chosen by doublet polarity
// [R3] unit-located errors swap but never count
// [R4] controller disables transmitters on recurring errors
// [R5] test uses ordinary wordstrings only
// [R6] test start inverts next complete wordstring
// [R7] busy at request: wait for next wordstring
// [R8] enter test only idle and last good
// [R9] test start clears status
// [R10] spare channel used on next wordstring
// [R11] results after end, quiet, then delay
// [R12] keep inverted if good, else revert
// [R13] code 3: incomplete, defective or disabled
// [R14] code 2: unit and both channels good
// [R15] code 1: one channel good only
// [R16] switch proven by wraparound polarity inversion
// [R17] code 0 fault stops transmit, test clears
// [R18] three unbroken changes enter coupler fault
// [R19] count mismatch toggles channel select
// [R20] quality problem deletes two manchester transitions
// [R21] controller holds idle flag low while sending
// [R22] two-bit status held until test/fault
// [R23] request line fall acts as test start
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module bsc_selftest
    import bsc_pkg::*;
#(
    parameter int CNT_W = 8
)(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output var  logic [31:0] o_avs_readdata,
    output var  logic        o_avs_waitrequest,
    input  wire bsc_link_t   i_link,
    input  wire logic        i_test_request_line,
    input  wire logic        i_transmitter_enable_line,
    input  wire logic        i_power_trip,
    input  wire logic        i_manch,
    output var  logic        o_manch,
    output var  logic        o_polarity,
    output var  logic        o_tx_enable,
    output var  logic [1:0]  o_status
);
    bsc_test_t          test_ff;
    logic               wait_ff;
    logic               idle_d_ff;
    logic               req_d_ff;
    logic               ws_done_ff;
    logic [CNT_W-1:0]   tx_cnt_ff;
    logic [CNT_W-1:0]   rx_cnt_ff;
    logic               ws_err_ff;
    logic               unit_ff;
    logic               inv_seen_ff;
    logic               lock_ff;
    logic               last_bad_ff;
    logic [1:0]         err_cnt_ff;
    logic               fault_ff;
    logic               pol_ff;
    logic [1:0]         result_ff;
    logic [6:0]         dly_ff;
    logic [1:0]         supp_ff;
    logic               manch_ff;
    logic               manch_d_ff;
    logic               txen_ff;
    logic [1:0]         stat_ff;
    logic [31:0]        rdata_ff;

    logic ws_start;
    logic ws_end;
    logic decide;
    logic bad;
    logic ts_cmd;
    logic bus_take;
    logic test_busy;
    logic test_done;
    logic test_good;
    logic normal_swap;

    // wordstring boundaries come from the controller's idle flag
    assign ws_start = idle_d_ff & ~i_link.tx_idle; // [R21]
    assign ws_end   = ~idle_d_ff & i_link.tx_idle;
    // channel decision only once the bus has gone quiet after the end
    assign decide   = ws_done_ff & i_link.bus_quiet & i_link.tx_idle;
    assign bad      = (tx_cnt_ff != rx_cnt_ff) | ws_err_ff; // [R1] [R19]
    // a write lands at the edge where the master sees waitrequest low
    assign bus_take = (i_avs_read | i_avs_write) & ~wait_ff;
    assign ts_cmd   = (bus_take & i_avs_write & (i_avs_address == ADDR_CTRL)
                      & i_avs_byteenable[0] & i_avs_writedata[CTRL_TS_BIT])
                      | (req_d_ff & ~i_test_request_line); // [R23]
    assign test_busy = (test_ff != T_IDLE);
    assign test_done = (test_ff == T_DELAY) & (dly_ff == 7'h00);
    // good inverted channel needs clean wraparound and proof of the switch
    assign test_good = ~last_bad_ff & inv_seen_ff; // [R14] [R16]
    // the test owns polarity in T_RUN, so no normal swap then
    assign normal_swap = decide & bad & ~lock_ff
                         & (test_ff != T_RUN) & ~fault_ff; // [R19]

    // bus slave: one wait cycle, then the answer
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            wait_ff <= 1'b1;
        else if ((i_avs_read | i_avs_write) & wait_ff)
            wait_ff <= 1'b0;
        else
            wait_ff <= 1'b1;
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            rdata_ff <= 32'h0000_0000;
        else if (i_avs_read & wait_ff)
        begin
            rdata_ff <= 32'h0000_0000;
            if (i_avs_address == ADDR_STAT)
            begin
                rdata_ff[STAT_CODE_LO +: 2]  <= stat_ff;
                rdata_ff[STAT_POL_BIT]      <= pol_ff;
                rdata_ff[STAT_FLT_BIT]      <= fault_ff;
                rdata_ff[STAT_ERR_LO +: 2]   <= err_cnt_ff;
                rdata_ff[STAT_BSY_BIT]      <= test_busy;
            end
        end
    end

    // edge history for the idle flag and the request line
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            idle_d_ff <= 1'b1;
            req_d_ff  <= 1'b1;
        end
        else
        begin
            idle_d_ff <= i_link.tx_idle;
            req_d_ff  <= i_test_request_line;
        end
    end

    // wordstring ended, waiting for bus quiet before deciding
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            ws_done_ff <= 1'b0;
        else if (ws_start)
            ws_done_ff <= 1'b0;
        else if (ws_end)
            ws_done_ff <= 1'b1;
        else if (decide)
            ws_done_ff <= 1'b0;
    end

    // doublet counts; wraparound may lag the end, so rx counts on
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            tx_cnt_ff <= '0;
            rx_cnt_ff <= '0;
        end
        else if (ws_start)
        begin
            tx_cnt_ff <= CNT_W'(i_link.tx_doublet);
            rx_cnt_ff <= CNT_W'(i_link.rx_doublet);
        end
        else
        begin
            if (i_link.tx_doublet)
                tx_cnt_ff <= tx_cnt_ff + CNT_W'(1); // [R5]
            if (i_link.rx_doublet)
                rx_cnt_ff <= rx_cnt_ff + CNT_W'(1); // [R1]
        end
    end

    // per-wordstring sticky observations; an event wins over the clear
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            ws_err_ff   <= 1'b0;
            unit_ff     <= 1'b0;
            inv_seen_ff <= 1'b0;
        end
        else
        begin
            ws_err_ff   <= (ws_err_ff & ~ws_start) | i_link.quality_err; // [R1]
            unit_ff     <= (unit_ff & ~ws_start) | i_link.unit_fault;
            inv_seen_ff <= (inv_seen_ff & ~ws_start)
                           | (i_link.wrap_inverted & ~i_link.tx_idle); // [R16]
        end
    end

    // result of the last monitored wordstring
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            last_bad_ff <= 1'b0;
        else if (decide & ~lock_ff)
            last_bad_ff <= bad;
        else if (decide & (test_ff == T_RUN))
            last_bad_ff <= bad;
    end

    // coupler error counter, frozen on the first swapped wordstring
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            err_cnt_ff <= 2'h0;
            lock_ff    <= 1'b0;
        end
        else if (ts_cmd)
        begin
            err_cnt_ff <= 2'h0;
            lock_ff    <= 1'b0;
        end
        else if (decide)
        begin
            lock_ff <= normal_swap;
            if (normal_swap & ~unit_ff)
                err_cnt_ff <= err_cnt_ff + 2'h1; // [R18] [R3]
            else if (~bad & ~lock_ff)
                err_cnt_ff <= 2'h0; // [R18]
        end
    end

    // coupler fault: only a test start leaves it
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            fault_ff <= 1'b0;
        else if (ts_cmd)
            fault_ff <= 1'b0; // [R17]
        else if (err_cnt_ff == ERR_LIMIT)
            fault_ff <= 1'b1; // [R18]
    end

    // channel select; swaps wait for a gap between wordstrings, the revert at test_done does not
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            pol_ff <= 1'b0;
        else if ((test_ff == T_ARMED) & i_link.tx_idle & ~ws_done_ff
                 & ~last_bad_ff & ~fault_ff)
            pol_ff <= ~pol_ff; // [R6] [R8]
        else if (test_done & ~test_good)
            pol_ff <= ~pol_ff; // [R12]
        else if (normal_swap)
            pol_ff <= ~pol_ff; // [R2] [R19] [R3]
    end

    // built-in test sequence
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            test_ff <= T_IDLE;
        else if (ts_cmd)
            test_ff <= T_ARMED;
        else
        begin
            case (test_ff)
                T_IDLE:
                    test_ff <= T_IDLE;
                T_ARMED:
                    if (i_link.tx_idle & ~ws_done_ff & ~last_bad_ff & ~fault_ff)
                        test_ff <= T_PRIMED; // [R7] [R8]
                T_PRIMED:
                    if (ws_start)
                        test_ff <= T_RUN; // [R10]
                T_RUN:
                    if (decide)
                        test_ff <= T_DELAY; // [R11]
                T_DELAY:
                    if (dly_ff == 7'h00)
                        test_ff <= T_IDLE;
                default:
                    test_ff <= T_IDLE;
            endcase
        end
    end

    // wraparound settle delay after the quiet bus
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            dly_ff <= WRAP_DELAY_CNT;
        else if (test_ff != T_DELAY)
            dly_ff <= WRAP_DELAY_CNT;
        else if (dly_ff != 7'h00)
            dly_ff <= dly_ff - 7'h01; // [R11]
    end

    // stored test result
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            result_ff <= RST_STATUS;
        else if (ts_cmd)
            result_ff <= ST_NONE; // [R9]
        else if (test_done)
            result_ff <= test_good ? ST_TWO : ST_ONE; // [R14] [R15]
    end

    // reported code; fault first, then anything that blocks the test
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            stat_ff <= RST_STATUS;
        else if (fault_ff & ~ts_cmd)
            stat_ff <= ST_FAULT; // [R17]
        else if (ts_cmd | test_busy | i_link.tx_defect
                 | ~i_transmitter_enable_line | i_power_trip)
            stat_ff <= ST_NONE; // [R13] [R9]
        else
            stat_ff <= result_ff; // [R22]
    end

    // transmitter enable; fault stops all transmission
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            txen_ff <= 1'b0;
        else
            txen_ff <= i_transmitter_enable_line & ~i_power_trip & ~fault_ff; // [R17]
    end

    // input history, so deletions count real transitions and not cycles
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
            manch_d_ff <= 1'b0;
        else
            manch_d_ff <= i_manch;
    end

    // regenerated manchester; a problem deletes the next two transitions
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            supp_ff  <= 2'h0;
            manch_ff <= 1'b0;
        end
        else if (i_link.quality_err)
        begin
            supp_ff  <= SUPP_TRANS; // [R20]
            manch_ff <= manch_ff;
        end
        else if (supp_ff != 2'h0)
        begin
            // output held while deleting; only an input edge uses one up
            if (i_manch != manch_d_ff)
                supp_ff <= supp_ff - 2'h1; // [R20]
        end
        else
            manch_ff <= i_manch;
    end

    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_manch           = manch_ff;
    assign o_polarity        = pol_ff;
    assign o_tx_enable       = txen_ff;
    assign o_status          = stat_ff;

    fault_stops_tx_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        fault_ff |=> !o_tx_enable) // [R17]
        else $error("transmitter on during coupler fault");
    fault_code_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (fault_ff && !ts_cmd) |=> (o_status == ST_FAULT)) // [R17]
        else $error("fault code missing");
    pol_steady_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (!i_link.tx_idle && !$past(i_link.tx_idle)) |-> $stable(o_polarity)) // [R2]
        else $error("polarity changed inside a wordstring");
    ts_clears_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        ts_cmd |=> (o_status == ST_NONE) && (result_ff == ST_NONE)) // [R9]
        else $error("test start did not clear status");
    err_limit_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (err_cnt_ff == ERR_LIMIT && !ts_cmd) |=> fault_ff) // [R18]
        else $error("three changes did not fault");
    unit_nocount_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (decide && unit_ff && !ts_cmd) |=> $stable(err_cnt_ff)) // [R3]
        else $error("unit error counted");
    settle_time_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (test_ff == T_RUN && decide && !ts_cmd) |=> (test_ff == T_DELAY)[*8]) // [R11]
        else $error("results too early");
    busy_no_test_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (test_busy && !fault_ff) |=> (o_status == ST_NONE)) // [R13]
        else $error("code 3 missing while test runs");
    manch_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        i_link.quality_err |=> $stable(o_manch)) // [R20]
        else $error("transition not deleted");
    swap_toggle_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        (normal_swap && test_ff != T_ARMED && !test_done) |=> (o_polarity != $past(o_polarity))) // [R19]
        else $error("mismatch did not toggle channel");
endmodule : bsc_selftest
`default_nettype wire

// file: dv/bsc_link_model.sv
// partner model: terminal controller and two-channel coupler seen at the stub
`timescale 1ns/100ps
`default_nettype none
module bsc_link_model
    import bsc_pkg::*;
(
    input  wire logic      i_clock,
    input  wire logic      i_defect,
    output var  bsc_link_t o_link
);
    bsc_link_t lk;

    // defect level is set by the bench, the rest by the send and pulse_q tasks
    always_comb
    begin
        o_link           = lk;
        o_link.tx_defect = i_defect;
    end

    // bus starts quiet with the controller idle
    initial
    begin
        lk           = '0;
        lk.tx_idle   = 1'b1;
        lk.bus_quiet = 1'b1;
    end

    // one wordstring: ntx doublets sent, nrx seen on wraparound
    task automatic send(input int ntx, input int nrx, input logic inv,
                        input logic qerr, input logic ufl);
        int i;
        int m;
        m = (ntx > nrx) ? ntx : nrx;
        @(posedge i_clock);
        lk.tx_idle       <= 1'b0; // idle flag low for the whole wordstring
        lk.bus_quiet     <= 1'b0;
        lk.wrap_inverted <= inv;
        for (i = 0; i < 2 * m; i++)
        begin
            @(posedge i_clock);
            lk.tx_doublet  <= (i % 2 == 0) && (i / 2 < ntx);
            lk.rx_doublet  <= (i % 2 == 0) && (i / 2 < nrx);
            lk.quality_err <= qerr && (i == 1);
            lk.unit_fault  <= ufl && (i == 1);
        end
        @(posedge i_clock);
        lk.tx_idle       <= 1'b1; // raised at the end of each wordstring
        lk.wrap_inverted <= 1'b0;
        repeat (3) @(posedge i_clock);
        lk.bus_quiet <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask : send

    // lone quality problem outside any wordstring
    task automatic pulse_q;
        @(posedge i_clock);
        lk.quality_err <= 1'b1;
        @(posedge i_clock);
        lk.quality_err <= 1'b0;
    endtask : pulse_q
endmodule : bsc_link_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the coupler self-test block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import bsc_pkg::*;
;
    logic        i_clock, i_rstn, rd, wr, req_line, en_line, trip, manch_in, defect;
    logic        wait_r, manch_out, pol, txen, pol_exp;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    logic [1:0]  status;
    logic [63:0] e;
    logic [63:0] expq[$];
    bsc_link_t   link;
    int          failures, n_checks, n, i;

    bsc_selftest uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
        .i_link(link), .i_test_request_line(req_line), .i_transmitter_enable_line(en_line),
        .i_power_trip(trip), .i_manch(manch_in), .o_manch(manch_out), .o_polarity(pol),
        .o_tx_enable(txen), .o_status(status));
    bsc_link_model lnk (.i_clock(i_clock), .i_defect(defect), .o_link(link));

    // 125 MHz clock
    initial
    begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        rd    <= !w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        do
            @(posedge i_clock);
        while (wait_r !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // note the masked expectation, then read
    task automatic rdq(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
        expq.push_back({msk, exp});
        bus(1'b0, a, 32'h0);
    endtask : rdq

    task automatic tick(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask : tick

    // read data is judged at the completing edge against the oldest note
    always @(posedge i_clock)
    begin
        if (rd === 1'b1 && wait_r === 1'b0)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : 64'hFFFFFFFF_FFFFFFFF;
            check(rdata & e[63:32], e[31:0] & e[63:32], "read data");
        end
    end

    // hang guard, far beyond the several hundred cycles the run needs
    initial
    begin
        #(8 * 20000);
        failures++;
        stop_test();
    end

    // main sequence
    initial
    begin
        failures = 0;
        n_checks = 0;
        {rd, wr, trip, manch_in, defect, i_rstn} = '0;
        {req_line, en_line} = 2'b11;
        addr    = 4'h0;
        wdata   = 32'h0;
        pol_exp = 1'b0;
        void'($urandom(32'h64A7));
        tick(6);
        check(status, ST_NONE, "reset status");
        check({pol, txen}, 2'b00, "reset pol/txen");
        @(posedge i_clock);
        i_rstn <= 1'b1;
        tick(3);
        check(txen, 1'b1, "tx enable");
        rdq(ADDR_STAT, 32'h3, 32'h7F);
        rdq(4'h8, 32'h0, 32'hFFFFFFFF);
        rdq(ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
        n = 3 + $urandom % 6;
        lnk.send(n, n, 1'b0, 1'b0, 1'b0);
        check(pol, pol_exp, "good keeps channel");
        // five bad wordstrings: every other one is the frozen first after a swap
        for (i = 0; i < 5; i++)
        begin
            n = 3 + $urandom % 6;
            lnk.send(n, n - 1, 1'b0, 1'b0, 1'b0);
            if (i % 2 == 0)
                pol_exp = ~pol_exp;
            check(pol, pol_exp, "mismatch swap");
            check(status, (i == 4) ? ST_FAULT : ST_NONE, "fault entry");
        end
        check(txen, 1'b0, "fault stops tx");
        rdq(ADDR_STAT, 32'h08, 32'h0B);
        bus(1'b1, ADDR_CTRL, 32'h1);
        tick(2);
        check(status, ST_NONE, "start clears");
        check(txen, 1'b1, "tx back");
        rdq(ADDR_STAT, 32'h43, 32'h4B);
        // last wordstring was bad, so the test waits for a good one
        check(pol, pol_exp, "no entry after bad");
        n = 3 + $urandom % 6;
        lnk.send(n, n, 1'b0, 1'b0, 1'b0);
        pol_exp = ~pol_exp;
        check(pol, pol_exp, "spare selected");
        // the spare is tried on an ordinary wordstring
        lnk.send(n, n, 1'b1, 1'b0, 1'b0);
        tick(WRAP_DELAY_CYC - 30);
        check(status, ST_NONE, "result waits");
        tick(40);
        check(status, ST_TWO, "both good");
        check(pol, pol_exp, "keep inverted");
        // request line falls in mid-wordstring
        fork
            lnk.send(n, n, 1'b0, 1'b0, 1'b0);
            begin
                tick(6);
                req_line <= 1'b0;
                tick(4);
                check(status, ST_NONE, "line start clears");
                check(pol, pol_exp, "no swap mid string");
            end
        join
        pol_exp = ~pol_exp;
        check(pol, pol_exp, "spare after string");
        req_line <= 1'b1;
        lnk.send(n, n, 1'b0, 1'b0, 1'b0);
        tick(WRAP_DELAY_CYC + 10);
        check(status, ST_ONE, "no inversion seen");
        pol_exp = ~pol_exp;
        check(pol, pol_exp, "revert channel");
        // unit-located errors never count toward the coupler fault
        for (i = 0; i < 6; i++)
            lnk.send(n, n - 1, 1'b0, 1'b0, 1'b1);
        check(status, ST_ONE, "no fault from unit");
        check(txen, 1'b1, "tx kept");
        @(posedge i_clock);
        defect <= 1'b1;
        tick(3);
        check(status, ST_NONE, "defective tx");
        defect  <= 1'b0;
        en_line <= 1'b0; // controller shuts transmitters down
        tick(3);
        check({txen, status}, {1'b0, ST_NONE}, "tx disabled");
        en_line <= 1'b1;
        trip    <= 1'b1;
        tick(3);
        check({txen, status}, {1'b0, ST_NONE}, "power trip");
        trip     <= 1'b0;
        manch_in <= 1'b1;
        tick(3);
        check(manch_out, 1'b1, "manchester pass");
        lnk.pulse_q();
        for (i = 0; i < 3; i++)
        begin
            manch_in <= ~manch_in;
            tick(3);
            check(manch_out, (i < 2) ? 1'b1 : 1'b0, "two changes dropped");
        end
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
